// ==== pkg/slcd_consts.vh ====
`ifndef SLCD_CONSTS_VH
`define SLCD_CONSTS_VH
// framing bytes
`define SLCD_ESC        8'h1B
`define SLCD_LBRACK     8'h5B
`define SLCD_SEMI       8'h3B
`define SLCD_DIG0       8'h30
`define SLCD_DIG9       8'h39
// command characters, matched case-sensitively
`define SLCD_CMD_POS    8'h48
`define SLCD_CMD_SAVE   8'h73
`define SLCD_CMD_REST   8'h75
`define SLCD_CMD_CLR    8'h6A
`define SLCD_CMD_ELINE  8'h4B
`define SLCD_CMD_EFLD   8'h4E
`define SLCD_CMD_SCRL   8'h40
`define SLCD_CMD_SCRR   8'h41
`define SLCD_CMD_RST    8'h2A
`define SLCD_CMD_DISP   8'h65
`define SLCD_CMD_WRAP   8'h68
`define SLCD_CMD_CURS   8'h63
`define SLCD_CMD_ADDR   8'h61
`define SLCD_CMD_BAUD   8'h62
`define SLCD_CMD_PROG   8'h70
`define SLCD_CMD_TSAVE  8'h74
`define SLCD_CMD_TLOAD  8'h6C
`define SLCD_CMD_GLYPH  8'h64
`define SLCD_CMD_MSAVE  8'h6D
`define SLCD_CMD_WEN    8'h57
`define SLCD_CMD_CSAVE  8'h6E
`define SLCD_CMD_DSAVE  8'h6F
// opcode of a plain character write
`define SLCD_OP_CHAR    8'h00
// geometry and ranges
`define SLCD_ROW_MAX    1'h1
`define SLCD_COL_MAX    6'h27
`define SLCD_WRAP_NARROW 6'h10
`define SLCD_WRAP_WIDE  6'h28
`define SLCD_GLYPH_MAX  8'h07
`define SLCD_GLYPH_NPAR 4'h8
`define SLCD_TBL_RAM    8'h03
`define SLCD_TBL_NVMAX  8'h02
`define SLCD_SEL_MAX2   8'h02
`define SLCD_SEL_MAX3   8'h03
`define SLCD_ROW_MASK   8'h3F
// strap codes after polarity fix
`define SLCD_STRAP_B2400 3'h0
`define SLCD_STRAP_B4800 3'h1
`define SLCD_STRAP_B9600 3'h2
`define SLCD_STRAP_BNV   3'h3
`define SLCD_STRAP_I2C   3'h4
`define SLCD_STRAP_I2CNV 3'h5
`define SLCD_STRAP_SPI   3'h6
`define SLCD_STRAP_NV    3'h7
`define SLCD_BAUD_2400  16'h0960
`define SLCD_BAUD_4800  16'h12C0
`define SLCD_BAUD_9600  16'h2580
`define SLCD_I2C_ADDR   7'h48
`endif

// ==== hdl/slcd_parser.v ====
// How it works
// R1: strap polarity flips with board revision input
// R2: strap code selects link, baud, address
// R3: plain bytes written as characters at cursor
// R4: ESC, bracket, semicolon params, command char
// R5: command characters compared case-sensitively
// R6: H positions cursor; s saves; u restores
// R7: j clears display, homes cursor
// R8: K erases end, start or whole line
// R9: N erases count characters from cursor
// R10: @ scrolls left, A scrolls right
// R11: e sets display and backlight together
// R12: h selects wrap at 16 or 40
// R13: c hides, shows or blinks cursor
// R14: b stores baud, a stores address
// R15: m, n, o store link, cursor, display modes
// R16: four glyph tables; p, t, l handle them
// R17: stores refused unless write-enable armed
// R18: write-enable covers only the next command
// R19: d takes eight rows then slot 0-7
// R20: row values use low six bits only
// R21: byte equal to slot draws that glyph
// R22: unknown or out-of-range sequences are dropped
`timescale 1ns/1ps
`include "slcd_consts.vh"
module slcd_parser #(
    parameter NPAR = 9
) (
    input  wire        clk_sys,
    input  wire        rst_n,
    input  wire [2:0]  modeStrapPins,
    input  wire        boardRevLate,
    input  wire        spiSclk,
    input  wire        spiMosi,
    input  wire        spiSelN,
    input  wire        rxValid,
    input  wire [7:0]  rxData,
    output reg  [2:0]  strapCode_r,
    output reg         linkSpi_r,
    output reg         linkI2c_r,
    output reg         linkUart_r,
    output reg         linkFromNv_r,
    output reg  [15:0] baudRate_r,
    output reg  [6:0]  i2cAddr_r,
    output reg         opValid_r,
    output reg  [7:0]  opCode_r,
    output reg  [7:0]  opArg0_r,
    output reg  [7:0]  opArg1_r,
    output reg  [47:0] glyphRows_r,
    output reg         cursorRow_r,
    output reg  [5:0]  cursorCol_r,
    output reg         dispOn_r,
    output reg         backlightOn_r,
    output reg         wrapWide_r,
    output reg  [1:0]  cursorMode_r,
    output reg         nvWe_r,
    output reg  [7:0]  nvSel_r,
    output reg  [7:0]  nvData_r,
    output reg         wrArmed_r
);
    localparam ST_IDLE = 3'b001;
    localparam ST_BRK  = 3'b010;
    localparam ST_PAR  = 3'b100;

    // two-flop synchronisers; link clock is sampled, not used as a clock
    reg [2:0] strapS1_r, strapS2_r;
    reg       revS1_r, revS2_r;
    reg [2:0] spiS1_r, spiS2_r;
    reg       sclkOld_r;
    reg [7:0] spiShift_r;
    reg [2:0] spiCnt_r;
    reg       spiDone_r;
    reg [7:0] spiByte_r;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            strapS1_r <= 3'h0;
            strapS2_r <= 3'h0;
            revS1_r   <= 1'b0;
            revS2_r   <= 1'b0;
            spiS1_r   <= 3'h4;
            spiS2_r   <= 3'h4;
            sclkOld_r <= 1'b0;
            spiShift_r <= 8'h00;
            spiCnt_r  <= 3'h0;
            spiDone_r <= 1'b0;
            spiByte_r <= 8'h00;
        end else begin
            strapS1_r <= modeStrapPins;
            strapS2_r <= strapS1_r;
            revS1_r   <= boardRevLate;
            revS2_r   <= revS1_r;
            spiS1_r   <= {spiSelN, spiSclk, spiMosi};
            spiS2_r   <= spiS1_r;
            sclkOld_r <= spiS2_r[1];
            spiDone_r <= 1'b0;
            if (spiS2_r[2]) begin
                spiCnt_r <= 3'h0;
            end else if (spiS2_r[1] && !sclkOld_r) begin
                spiShift_r <= {spiShift_r[6:0], spiS2_r[0]};
                spiCnt_r   <= spiCnt_r + 3'h1;
                if (spiCnt_r == 3'h7) begin
                    spiDone_r <= 1'b1;
                    spiByte_r <= {spiShift_r[6:0], spiS2_r[0]};
                end
            end
        end
    end

    // later boards read an absent strap as 1, so invert to one code space
    wire [2:0] strapNorm = revS2_r ? ~strapS2_r : strapS2_r; // [R1]

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            strapCode_r  <= 3'h0;
            linkSpi_r    <= 1'b0;
            linkI2c_r    <= 1'b0;
            linkUart_r   <= 1'b0;
            linkFromNv_r <= 1'b0;
            baudRate_r   <= 16'h0000;
            i2cAddr_r    <= 7'h00;
        end else begin
            strapCode_r  <= strapNorm;
            linkSpi_r    <= (strapNorm == `SLCD_STRAP_SPI); // [R2]
            linkI2c_r    <= (strapNorm == `SLCD_STRAP_I2C) || (strapNorm == `SLCD_STRAP_I2CNV);
            linkUart_r   <= (strapNorm <= `SLCD_STRAP_BNV);
            linkFromNv_r <= (strapNorm == `SLCD_STRAP_BNV) || (strapNorm == `SLCD_STRAP_I2CNV)
                            || (strapNorm == `SLCD_STRAP_NV);
            baudRate_r   <= (strapNorm == `SLCD_STRAP_B2400) ? `SLCD_BAUD_2400 :
                            (strapNorm == `SLCD_STRAP_B4800) ? `SLCD_BAUD_4800 :
                            (strapNorm == `SLCD_STRAP_B9600) ? `SLCD_BAUD_9600 : 16'h0000;
            i2cAddr_r    <= (strapNorm == `SLCD_STRAP_I2C) ? `SLCD_I2C_ADDR : 7'h00;
        end
    end

    // non-spi links deliver bytes from an outside receiver on this clock
    wire       byteValid = linkSpi_r ? spiDone_r : rxValid;
    wire [7:0] byteIn    = linkSpi_r ? spiByte_r : rxData;
    wire       isDigit   = (byteIn >= `SLCD_DIG0) && (byteIn <= `SLCD_DIG9);
    wire [7:0] digitVal  = byteIn - `SLCD_DIG0;

    reg [2:0]  state_r;
    reg [7:0]  par_r [0:NPAR-1];
    reg [3:0]  pIdx_r;
    reg        pOvf_r;
    reg        savedRow_r;
    reg [5:0]  savedCol_r;
    integer    i;

    wire [7:0] p0 = par_r[0];
    wire [7:0] p1 = par_r[1];
    wire [5:0] wrapW = wrapWide_r ? `SLCD_WRAP_WIDE : `SLCD_WRAP_NARROW; // [R12]
    // wide enough for 255*10+9, so an overflow can never wrap out of sight
    wire [11:0] accNxt = {4'h0, par_r[pIdx_r]} * 12'd10 + {4'h0, digitVal};
    wire       isNvCmd = (byteIn == `SLCD_CMD_ADDR) || (byteIn == `SLCD_CMD_BAUD)
                       || (byteIn == `SLCD_CMD_TSAVE) || (byteIn == `SLCD_CMD_MSAVE)
                       || (byteIn == `SLCD_CMD_CSAVE) || (byteIn == `SLCD_CMD_DSAVE);

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            for (i = 0; i < NPAR; i = i + 1)
                par_r[i] <= 8'h00;
            pIdx_r <= 4'h0;
            pOvf_r <= 1'b0;
            savedRow_r <= 1'b0;
            savedCol_r <= 6'h00;
            opValid_r <= 1'b0;
            opCode_r <= 8'h00;
            opArg0_r <= 8'h00;
            opArg1_r <= 8'h00;
            glyphRows_r <= 48'h0000_0000_0000;
            cursorRow_r <= 1'b0;
            cursorCol_r <= 6'h00;
            dispOn_r <= 1'b1;
            backlightOn_r <= 1'b1;
            wrapWide_r <= 1'b0;
            cursorMode_r <= 2'h0;
            nvWe_r <= 1'b0;
            nvSel_r <= 8'h00;
            nvData_r <= 8'h00;
            wrArmed_r <= 1'b0;
        end else begin
            opValid_r <= 1'b0;
            nvWe_r <= 1'b0;
            if (byteValid) begin
                case (state_r)
                ST_IDLE: begin
                    if (byteIn == `SLCD_ESC) begin
                        state_r <= ST_BRK; // [R4]
                    end else begin
                        // codes 0..7 are glyph slots, drawn like any character
                        opValid_r <= 1'b1; // [R3] [R21]
                        opCode_r  <= `SLCD_OP_CHAR;
                        opArg0_r  <= byteIn;
                        opArg1_r  <= {2'b00, cursorCol_r};
                        wrArmed_r <= 1'b0; // [R18]
                        if (cursorCol_r + 6'h01 >= wrapW) begin
                            cursorCol_r <= 6'h00;
                            cursorRow_r <= ~cursorRow_r;
                        end else begin
                            cursorCol_r <= cursorCol_r + 6'h01;
                        end
                    end
                end
                ST_BRK: begin
                    for (i = 0; i < NPAR; i = i + 1)
                        par_r[i] <= 8'h00;
                    pIdx_r <= 4'h0;
                    pOvf_r <= 1'b0;
                    state_r <= (byteIn == `SLCD_LBRACK) ? ST_PAR : ST_IDLE; // [R4] [R22]
                end
                ST_PAR: begin
                    if (isDigit) begin
                        if (accNxt > 12'd255)
                            pOvf_r <= 1'b1;
                        par_r[pIdx_r] <= accNxt[7:0];
                    end else if (byteIn == `SLCD_SEMI) begin
                        if (pIdx_r == NPAR - 1)
                            pOvf_r <= 1'b1;
                        else
                            pIdx_r <= pIdx_r + 4'h1;
                    end else begin
                        state_r <= ST_IDLE;
                        wrArmed_r <= (byteIn == `SLCD_CMD_WEN) && !pOvf_r; // [R18]
                        opCode_r <= byteIn;
                        opArg0_r <= p0;
                        opArg1_r <= p1;
                        if (!pOvf_r) begin // [R22]
                            // exact byte compare keeps upper and lower case apart
                            case (byteIn) // [R5]
                            `SLCD_CMD_POS: if (p0 <= `SLCD_ROW_MAX && p1 <= `SLCD_COL_MAX) begin
                                cursorRow_r <= p0[0]; // [R6]
                                cursorCol_r <= p1[5:0];
                            end
                            `SLCD_CMD_SAVE: begin
                                savedRow_r <= cursorRow_r; // [R6]
                                savedCol_r <= cursorCol_r;
                            end
                            `SLCD_CMD_REST: begin
                                cursorRow_r <= savedRow_r; // [R6]
                                cursorCol_r <= savedCol_r;
                            end
                            `SLCD_CMD_CLR: begin
                                opValid_r <= 1'b1; // [R7]
                                cursorRow_r <= 1'b0;
                                cursorCol_r <= 6'h00;
                            end
                            `SLCD_CMD_ELINE: if (p0 <= `SLCD_SEL_MAX2) begin
                                opValid_r <= 1'b1; // [R8]
                                opArg1_r <= {2'b00, cursorCol_r};
                            end
                            `SLCD_CMD_EFLD: begin
                                opValid_r <= 1'b1; // [R9]
                                opArg1_r <= {2'b00, cursorCol_r};
                            end
                            `SLCD_CMD_SCRL, `SLCD_CMD_SCRR: opValid_r <= 1'b1; // [R10]
                            `SLCD_CMD_RST: begin
                                opValid_r <= 1'b1;
                                cursorRow_r <= 1'b0;
                                cursorCol_r <= 6'h00;
                                savedRow_r <= 1'b0;
                                savedCol_r <= 6'h00;
                                dispOn_r <= 1'b1;
                                backlightOn_r <= 1'b1;
                                wrapWide_r <= 1'b0;
                                cursorMode_r <= 2'h0;
                                wrArmed_r <= 1'b0;
                            end
                            `SLCD_CMD_DISP: if (p0 <= `SLCD_SEL_MAX3) begin
                                dispOn_r <= p0[0]; // [R11]
                                backlightOn_r <= p0[1];
                            end
                            `SLCD_CMD_WRAP: if (p0 <= 8'h01)
                                wrapWide_r <= p0[0]; // [R12]
                            `SLCD_CMD_CURS: if (p0 <= `SLCD_SEL_MAX2)
                                cursorMode_r <= p0[1:0]; // [R13]
                            `SLCD_CMD_PROG: if (p0 <= `SLCD_TBL_RAM)
                                opValid_r <= 1'b1; // [R16]
                            `SLCD_CMD_TLOAD: if (p0 <= `SLCD_TBL_NVMAX)
                                opValid_r <= 1'b1; // [R16]
                            `SLCD_CMD_GLYPH: if (pIdx_r == `SLCD_GLYPH_NPAR
                                                 && par_r[8] <= `SLCD_GLYPH_MAX) begin
                                opValid_r <= 1'b1; // [R19]
                                opArg0_r <= par_r[8];
                                glyphRows_r <= {par_r[0][5:0], par_r[1][5:0], // [R20]
                                                par_r[2][5:0], par_r[3][5:0],
                                                par_r[4][5:0], par_r[5][5:0],
                                                par_r[6][5:0], par_r[7][5:0]};
                            end
                            default: ;
                            endcase
                            // stores happen only right after a write-enable
                            if (isNvCmd && wrArmed_r && !(byteIn == `SLCD_CMD_TSAVE
                                                         && p0 > `SLCD_TBL_NVMAX)) begin
                                nvWe_r <= 1'b1; // [R14] [R15] [R16] [R17]
                                nvSel_r <= byteIn;
                                nvData_r <= p0;
                            end
                        end
                    end
                end
                default: state_r <= ST_IDLE;
                endcase
            end
        end
    end
endmodule

// ==== sim/slcd_parser_assertions.sv ====
`timescale 1ns/1ps
`include "slcd_consts.vh"
module slcd_parser_assertions #(
    parameter NPAR = 9
) (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic [2:0]  modeStrapPins,
    input wire logic        boardRevLate,
    input wire logic        rxValid,
    input wire logic [7:0]  rxData,
    input wire logic [2:0]  strapCode_r,
    input wire logic        linkSpi_r,
    input wire logic        linkI2c_r,
    input wire logic        linkUart_r,
    input wire logic [15:0] baudRate_r,
    input wire logic [6:0]  i2cAddr_r,
    input wire logic        opValid_r,
    input wire logic [7:0]  opCode_r,
    input wire logic [7:0]  opArg0_r,
    input wire logic [7:0]  opArg1_r,
    input wire logic        cursorRow_r,
    input wire logic [5:0]  cursorCol_r,
    input wire logic        wrapWide_r,
    input wire logic        nvWe_r,
    input wire logic        wrArmed_r
);
    logic escPend_r;
    logic escPend_nxt;
    wire  byteTaken = rxValid && !linkSpi_r;
    wire  isDigit   = rxData >= `SLCD_DIG0 && rxData <= `SLCD_DIG9;
    // tracks only well-formed sequences; the bench sends no malformed prefixes
    assign escPend_nxt = !byteTaken ? escPend_r : (rxData == `SLCD_ESC) ||
        (escPend_r && (isDigit || rxData == `SLCD_LBRACK || rxData == `SLCD_SEMI));
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) escPend_r <= 1'b0;
        else escPend_r <= escPend_nxt;
    end
    default clocking dcb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    property p_strapPol;
        ($stable(modeStrapPins) && $stable(boardRevLate)) [*5] |->
            strapCode_r == (boardRevLate ? ~modeStrapPins : modeStrapPins);
    endproperty
    a_strapPol: assert property (p_strapPol) else $error("strap polarity wrong");
    property p_linkSpi;
        (strapCode_r == `SLCD_STRAP_SPI) [*2] |-> linkSpi_r && !linkUart_r && !linkI2c_r;
    endproperty
    a_linkSpi: assert property (p_linkSpi) else $error("spi link not chosen");
    property p_i2cAddr;
        (strapCode_r == `SLCD_STRAP_I2C) [*2] |-> linkI2c_r && i2cAddr_r == `SLCD_I2C_ADDR;
    endproperty
    a_i2cAddr: assert property (p_i2cAddr) else $error("i2c address wrong");
    property p_baud;
        (strapCode_r == `SLCD_STRAP_B9600) [*2] |-> linkUart_r && baudRate_r == `SLCD_BAUD_9600;
    endproperty
    a_baud: assert property (p_baud) else $error("uart baud wrong");
    property p_char;
        byteTaken && !escPend_r && rxData != `SLCD_ESC |=> opValid_r &&
            opCode_r == `SLCD_OP_CHAR && opArg0_r == $past(rxData);
    endproperty
    a_char: assert property (p_char) else $error("plain byte not written");
    property p_colStep;
        opValid_r && opCode_r == `SLCD_OP_CHAR && !wrapWide_r && opArg1_r[5:0] < 6'h0F
            |-> cursorCol_r == opArg1_r[5:0] + 6'h01;
    endproperty
    a_colStep: assert property (p_colStep) else $error("cursor did not advance");
    property p_wrap;
        opValid_r && opCode_r == `SLCD_OP_CHAR && !wrapWide_r && opArg1_r[5:0] == 6'h0F
            |-> cursorCol_r == 6'h00 && cursorRow_r != $past(cursorRow_r);
    endproperty
    a_wrap: assert property (p_wrap) else $error("narrow wrap wrong");
    property p_armedStore;
        nvWe_r |-> $past(wrArmed_r) && !wrArmed_r;
    endproperty
    a_armedStore: assert property (p_armedStore) else $error("store not armed");
    property p_noUnarmed;
        byteTaken && !wrArmed_r |=> !nvWe_r;
    endproperty
    a_noUnarmed: assert property (p_noUnarmed) else $error("unarmed store");
    property p_glyphSlot;
        opValid_r && opCode_r == `SLCD_CMD_GLYPH |-> opArg0_r <= `SLCD_GLYPH_MAX;
    endproperty
    a_glyphSlot: assert property (p_glyphSlot) else $error("glyph slot range");
    property p_colRange;
        cursorCol_r <= `SLCD_COL_MAX;
    endproperty
    a_colRange: assert property (p_colRange) else $error("column out of range");
    c_store: cover property (nvWe_r);
    c_glyph: cover property (opValid_r && opCode_r == `SLCD_CMD_GLYPH);
    c_wrap: cover property (opValid_r && opCode_r == `SLCD_OP_CHAR && opArg1_r == 8'h0F);
endmodule
bind slcd_parser slcd_parser_assertions #(.NPAR(NPAR)) i_chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .modeStrapPins(modeStrapPins),
    .boardRevLate(boardRevLate), .rxValid(rxValid), .rxData(rxData),
    .strapCode_r(strapCode_r), .linkSpi_r(linkSpi_r), .linkI2c_r(linkI2c_r),
    .linkUart_r(linkUart_r), .baudRate_r(baudRate_r), .i2cAddr_r(i2cAddr_r),
    .opValid_r(opValid_r), .opCode_r(opCode_r), .opArg0_r(opArg0_r), .opArg1_r(opArg1_r),
    .cursorRow_r(cursorRow_r), .cursorCol_r(cursorCol_r), .wrapWide_r(wrapWide_r),
    .nvWe_r(nvWe_r), .wrArmed_r(wrArmed_r)
);

// ==== sim/slcd_host_model.sv ====
`timescale 1ns/1ps
module slcd_host_model (
    output logic spiSclk,
    output logic spiMosi,
    output logic spiSelN
);
    initial begin
        spiSclk = 1'b0;
        spiMosi = 1'b0;
        spiSelN = 1'b1;
    end
    // mode 0, msb first; clock parked low between frames
    task spiByte(input logic [7:0] b);
        spiSelN = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            spiMosi = b[i];
            #40 spiSclk = 1'b1;
            #40 spiSclk = 1'b0;
        end
        #40 spiSelN = 1'b1;
        // released line must not look like held data
        spiMosi = ~spiMosi;
    endtask
endmodule

// ==== sim/test_slcd_parser.sv ====
`timescale 1ns/1ps
`define CHK(nm, ex, sn) begin n_compared++; if ((sn) !== (ex)) begin n_mismatch++; \
    $display("BAD %s exp %0h got %0h", nm, ex, sn); end end
module test_slcd_parser;
    logic        clk_sys, rst_n, boardRevLate, rxValid;
    logic [2:0]  modeStrapPins;
    logic [7:0]  rxData;
    int          n_mismatch, n_compared, n;
    wire         spiSclk, spiMosi, spiSelN, linkSpi_r, linkI2c_r, linkUart_r, linkFromNv_r;
    wire         opValid_r, cursorRow_r, dispOn_r, backlightOn_r, wrapWide_r, nvWe_r, wrArmed_r;
    wire [2:0]   strapCode_r;
    wire [15:0]  baudRate_r;
    wire [6:0]   i2cAddr_r;
    wire [7:0]   opCode_r, opArg0_r, opArg1_r, nvSel_r, nvData_r;
    wire [47:0]  glyphRows_r;
    wire [5:0]   cursorCol_r;
    wire [1:0]   cursorMode_r;
    string       opStr[9] = '{"0K", "1K", "2K", "3N", "2@", "2A", "3p", "1l", "0*"};
    logic [7:0]  opArg[9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h02, 8'h02, 8'h03, 8'h01, 8'h00};
    string       nvStr[6] = '{"2a", "9b", "1m", "2n", "3o", "2t"};
    slcd_host_model host (.spiSclk(spiSclk), .spiMosi(spiMosi), .spiSelN(spiSelN));
    slcd_parser #(.NPAR(9)) i_slcd_parser (
        .clk_sys(clk_sys), .rst_n(rst_n), .modeStrapPins(modeStrapPins),
        .boardRevLate(boardRevLate), .spiSclk(spiSclk), .spiMosi(spiMosi), .spiSelN(spiSelN),
        .rxValid(rxValid), .rxData(rxData), .strapCode_r(strapCode_r), .linkSpi_r(linkSpi_r),
        .linkI2c_r(linkI2c_r), .linkUart_r(linkUart_r), .linkFromNv_r(linkFromNv_r),
        .baudRate_r(baudRate_r), .i2cAddr_r(i2cAddr_r), .opValid_r(opValid_r),
        .opCode_r(opCode_r), .opArg0_r(opArg0_r), .opArg1_r(opArg1_r),
        .glyphRows_r(glyphRows_r), .cursorRow_r(cursorRow_r), .cursorCol_r(cursorCol_r),
        .dispOn_r(dispOn_r), .backlightOn_r(backlightOn_r), .wrapWide_r(wrapWide_r),
        .cursorMode_r(cursorMode_r), .nvWe_r(nvWe_r), .nvSel_r(nvSel_r),
        .nvData_r(nvData_r), .wrArmed_r(wrArmed_r)
    );
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    task results;
        $display("mismatches %0d compared %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // valid held high across a string, so bytes arrive back to back
    task sendStr(input string s);
        @(posedge clk_sys);
        #1;
        for (int i = 0; i < s.len(); i++) begin
            rxValid = 1'b1;
            rxData = s[i];
            @(posedge clk_sys);
            #1;
        end
        rxValid = 1'b0;
    endtask
    task esc(input string s);
        sendStr({"\033[", s});
    endtask
    task setStrap(input logic rev, input logic [2:0] code);
        boardRevLate = rev;
        modeStrapPins = rev ? ~code : code;
        repeat (6) @(posedge clk_sys);
        #1;
    endtask
    initial begin
        n_mismatch = 0;
        n_compared = 0;
        {rst_n, rxValid, rxData, boardRevLate, modeStrapPins} = {1'b0, 1'b0, 8'h00, 1'b0, 3'h2};
        repeat (16) @(posedge clk_sys);
        #1;
        `CHK("dispOnRst", 1'b1, dispOn_r)
        `CHK("lightRst", 1'b1, backlightOn_r)
        `CHK("cursModeRst", 2'h0, cursorMode_r)
        rst_n = 1'b1;
        for (int r = 0; r < 2; r++) begin
            for (int c = 0; c < 8; c++) begin
                setStrap(r[0], c[2:0]);
                `CHK("strap", c[2:0], strapCode_r)
                `CHK("spi", c == 6, linkSpi_r)
                `CHK("fromNv", c == 3 || c == 5 || c == 7, linkFromNv_r)
                if (c < 7) begin
                    `CHK("uart", c < 4, linkUart_r)
                    `CHK("i2c", c == 4 || c == 5, linkI2c_r)
                    `CHK("i2cAddr", (c == 4 ? 7'h48 : 7'h00), i2cAddr_r)
                    `CHK("baud", (c == 0 ? 16'h0960 : c == 1 ? 16'h12C0 :
                        c == 2 ? 16'h2580 : 16'h0000), baudRate_r)
                end
            end
        end
        setStrap(1'b0, 3'h2);
        esc("1;5H");
        `CHK("row", 1'b1, cursorRow_r)
        `CHK("col", 6'h05, cursorCol_r)
        sendStr("B");
        `CHK("charArg", 8'h42, opArg0_r)
        `CHK("charCol", 8'h05, opArg1_r)
        esc("s");
        esc("0;0H");
        esc("u");
        `CHK("restore", 6'h06, cursorCol_r)
        esc("2;0H");
        `CHK("badRow", 6'h06, cursorCol_r)
        esc("2k");
        `CHK("lowerK", 1'b0, opValid_r)
        sendStr("x");
        `CHK("afterBad", 8'h00, opCode_r)
        foreach (opStr[k]) begin
            esc(opStr[k]);
            `CHK("op", 1'b1, opValid_r)
            `CHK("opCode", opStr[k][1], opCode_r)
            `CHK("opArg", opArg[k], opArg0_r)
        end
        esc("3l");
        `CHK("tblRange", 1'b0, opValid_r)
        esc("j");
        `CHK("clear", 8'h6A, opCode_r)
        `CHK("home", 7'h00, {cursorRow_r, cursorCol_r})
        for (int s = 0; s < 4; s++) begin
            esc($sformatf("%0de", s));
            `CHK("disp", s[0], dispOn_r)
            `CHK("light", s[1], backlightOn_r)
        end
        esc("4e");
        `CHK("dispKeep", 2'h3, {dispOn_r, backlightOn_r})
        for (int s = 0; s < 3; s++) begin
            esc($sformatf("%0dc", s));
            `CHK("cursMode", s[1:0], cursorMode_r)
        end
        for (int s = 1; s >= 0; s--) begin
            esc($sformatf("%0dh", s));
            `CHK("wrap", s[0], wrapWide_r)
        end
        esc("0;15H");
        sendStr("W");
        `CHK("wrapPos", 7'h40, {cursorRow_r, cursorCol_r})
        esc("9b");
        `CHK("unarmed", 1'b0, nvWe_r)
        foreach (nvStr[k]) begin
            esc("W");
            `CHK("armed", 1'b1, wrArmed_r)
            esc(nvStr[k]);
            `CHK("nvWe", 1'b1, nvWe_r)
            `CHK("nvSel", nvStr[k][1], nvSel_r)
            `CHK("nvData", nvStr[k][0] - 8'h30, nvData_r)
            `CHK("disarm", 1'b0, wrArmed_r)
        end
        esc("9b");
        `CHK("reuse", 1'b0, nvWe_r)
        esc("W");
        sendStr("q");
        esc("9b");
        `CHK("stale", 1'b0, nvWe_r)
        esc("W");
        esc("3t");
        `CHK("ramStore", 1'b0, nvWe_r)
        esc("78;31;21;31;23;16;31;14;5d");
        `CHK("glyphOp", 8'h64, opCode_r)
        `CHK("slot", 8'h05, opArg0_r)
        `CHK("rows", ({6'h0E, 6'h1F, 6'h15, 6'h1F, 6'h17, 6'h10, 6'h1F, 6'h0E}),
            glyphRows_r)
        esc("1;2;3;4;5;6;7;8d");
        `CHK("shortGlyph", 1'b0, opValid_r)
        sendStr("\005");
        `CHK("glyphDraw", 16'h0005, {opCode_r, opArg0_r})
        setStrap(1'b0, 3'h6);
        sendStr("Q");
        `CHK("rxIgnored", 1'b0, opValid_r)
        fork
            host.spiByte(8'h5A);
            for (n = 0; n < 400 && opValid_r !== 1'b1; n++) begin
                @(posedge clk_sys);
                #1;
            end
        join
        if (n == 400)
            n_mismatch++;
        `CHK("spiChar", 8'h5A, opArg0_r)
        results();
    end
endmodule
